// ==== verilog/encsim_regs.svh ====
// Register offsets, field positions, reset values and timing counts
`ifndef ENCSIM_REGS_SVH
`define ENCSIM_REGS_SVH

// Register byte offsets
`define ENCSIM_PPR_OFS 4'h0
`define ENCSIM_CTRL_OFS 4'h4
`define ENCSIM_PTR_OFS 4'h8
`define ENCSIM_STAT_OFS 4'hC

// Control field positions
`define ENCSIM_EXP_BIT 0
`define ENCSIM_SRC_BIT 3
`define ENCSIM_SCALED_BIT 8

// Reset values
`define ENCSIM_PPR_RST 16'h0400
`define ENCSIM_CTRL_RST 16'h0000
`define ENCSIM_PTR_RST 16'h0000

// Resolution limits
`define ENCSIM_PPR_MIN 16'h0004
`define ENCSIM_EXP_MAX 16'h0012
`define ENCSIM_POS_BITS 20

// Timing: output pulse ceiling and clock rate
`define ENCSIM_MAX_FREQ_KHZ 400
`define ENCSIM_CLK_MHZ 100
`define ENCSIM_EDGE_CYC ((`ENCSIM_CLK_MHZ * 1000 + 4 * `ENCSIM_MAX_FREQ_KHZ - 1) / (4 * `ENCSIM_MAX_FREQ_KHZ))

`endif

// ==== verilog/encsim_pkg.sv ====
// Types shared by the encoder simulation output block
package encsim_pkg;

  // One set of simulated encoder lines
  typedef struct packed {
    logic a;
    logic b;
    logic c;
  } enc_lines_s;

  // Control bits as held by the block
  typedef struct packed {
    logic scaled;
    logic src_param;
    logic exp_sel;
  } sim_ctrl_s;

endpackage : encsim_pkg

// ==== verilog/encoder_simulation_output.sv ====
// Encoder simulation output: quadrature A/B and zero trace C from a position
//
// The address map and the AXI4-Lite register port were left to the implementer.

`timescale 1ns/1ps
`default_nettype none
`include "encsim_regs.svh"

module encoder_simulation_output
  import encsim_pkg::*;
(
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic CE,
  // AXI4-Lite slave
  input wire logic [3:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [3:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // Position sources, same clock domain
  input wire logic [19:0] SHAFT_POS,
  input wire logic [31:0] PARAM_VALUE,
  output logic [15:0] SIM_SOURCE_POINTER,
  // Two connectors
  output enc_lines_s ENC_OUT1,
  output enc_lines_s ENC_OUT2
);

  //--------------------------------------------------------------
  // Declarations
  //--------------------------------------------------------------
  localparam logic [5:0] EDGE_GAP = 6'(`ENCSIM_EDGE_CYC - 1);

  logic [15:0] sim_pulses_per_rev;
  sim_ctrl_s ctrl;
  logic [3:0] aw_addr;
  logic aw_got;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic w_got;
  logic [15:0] wr_ppr;
  logic [15:0] wr_ptr;
  logic [15:0] wr_ctrl;
  logic wr_ok;
  logic [31:0] rd_word;
  logic rd_ok;
  logic [19:0] pos;
  logic [15:0] ppr_lin;
  logic [4:0] ppr_exp;
  logic [35:0] prod;
  logic [20:0] span;
  logic [20:0] target;
  logic [20:0] span_q;
  logic [20:0] target_q;
  logic [20:0] cur;
  logic [21:0] diff;
  logic [20:0] fwd;
  logic [5:0] gap;
  logic step_up;
  logic step_dn;
  enc_lines_s next_lines;

  //--------------------------------------------------------------
  // AXI4-Lite write path
  //--------------------------------------------------------------

  // Write address: one-cycle ready, address held until used
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      S_AXI_AWREADY <= 1'b0;
      aw_got <= 1'b0;
      aw_addr <= 4'h0;
    end else if (CE) begin
      S_AXI_AWREADY <= S_AXI_AWVALID && !aw_got && !S_AXI_AWREADY && !S_AXI_BVALID;
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_got <= 1'b1;
        aw_addr <= S_AXI_AWADDR;
      end else if (aw_got && w_got && !S_AXI_BVALID) begin
        aw_got <= 1'b0;
      end
    end
  end

  // Write data: taken independently of the address
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      S_AXI_WREADY <= 1'b0;
      w_got <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (CE) begin
      S_AXI_WREADY <= S_AXI_WVALID && !w_got && !S_AXI_WREADY && !S_AXI_BVALID;
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_got <= 1'b1;
        w_data <= S_AXI_WDATA;
        w_strb <= S_AXI_WSTRB;
      end else if (aw_got && w_got && !S_AXI_BVALID) begin
        w_got <= 1'b0;
      end
    end
  end

  // Byte-lane merge and address decode for a write
  always_comb begin
    wr_ppr = sim_pulses_per_rev;
    wr_ptr = SIM_SOURCE_POINTER;
    wr_ctrl = 16'h0000;
    wr_ctrl[`ENCSIM_EXP_BIT] = ctrl.exp_sel;
    wr_ctrl[`ENCSIM_SRC_BIT] = ctrl.src_param;
    wr_ctrl[`ENCSIM_SCALED_BIT] = ctrl.scaled;
    if (w_strb[0]) begin
      wr_ppr[7:0] = w_data[7:0];
      wr_ptr[7:0] = w_data[7:0];
      wr_ctrl[7:0] = w_data[7:0];
    end
    if (w_strb[1]) begin
      wr_ppr[15:8] = w_data[15:8];
      wr_ptr[15:8] = w_data[15:8];
      wr_ctrl[15:8] = w_data[15:8];
    end
    case (aw_addr)
      `ENCSIM_PPR_OFS: wr_ok = 1'b1;
      `ENCSIM_CTRL_OFS: wr_ok = 1'b1;
      `ENCSIM_PTR_OFS: wr_ok = 1'b1;
      `ENCSIM_STAT_OFS: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end

  // Register update and write response
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      sim_pulses_per_rev <= `ENCSIM_PPR_RST;
      ctrl <= 3'b000;
      SIM_SOURCE_POINTER <= `ENCSIM_PTR_RST;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= 2'b00;
    end else if (CE) begin
      if (aw_got && w_got && !S_AXI_BVALID) begin
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= wr_ok ? 2'b00 : 2'b10;
        case (aw_addr)
          `ENCSIM_PPR_OFS: sim_pulses_per_rev <= wr_ppr;
          `ENCSIM_CTRL_OFS: begin
            ctrl.exp_sel <= wr_ctrl[`ENCSIM_EXP_BIT];
            ctrl.src_param <= wr_ctrl[`ENCSIM_SRC_BIT];
            ctrl.scaled <= wr_ctrl[`ENCSIM_SCALED_BIT];
          end
          `ENCSIM_PTR_OFS: SIM_SOURCE_POINTER <= wr_ptr;
          default: ;
        endcase
      end else if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
    end
  end

  //--------------------------------------------------------------
  // AXI4-Lite read path
  //--------------------------------------------------------------

  // Read decode, unused bits read as zero
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_ok = 1'b1;
    case (S_AXI_ARADDR)
      `ENCSIM_PPR_OFS: rd_word[15:0] = sim_pulses_per_rev;
      `ENCSIM_CTRL_OFS: begin
        rd_word[`ENCSIM_EXP_BIT] = ctrl.exp_sel;
        rd_word[`ENCSIM_SRC_BIT] = ctrl.src_param;
        rd_word[`ENCSIM_SCALED_BIT] = ctrl.scaled;
      end
      `ENCSIM_PTR_OFS: rd_word[15:0] = SIM_SOURCE_POINTER;
      `ENCSIM_STAT_OFS: rd_word[20:0] = cur;
      default: rd_ok = 1'b0;
    endcase
  end

  // Read handshake with registered data
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h0000_0000;
      S_AXI_RRESP <= 2'b00;
    end else if (CE) begin
      S_AXI_ARREADY <= S_AXI_ARVALID && !S_AXI_ARREADY && !S_AXI_RVALID;
      if (S_AXI_ARVALID && S_AXI_ARREADY) begin
        S_AXI_RVALID <= 1'b1;
        S_AXI_RDATA <= rd_word;
        S_AXI_RRESP <= rd_ok ? 2'b00 : 2'b10;
      end else if (S_AXI_RVALID && S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
      end
    end
  end

  //--------------------------------------------------------------
  // Position source and resolution
  //--------------------------------------------------------------

  // Source pick: shaft at 2^20, parameter as fraction of a turn
  always_comb begin
    if (!ctrl.src_param) begin
      pos = SHAFT_POS;
    end else if (ctrl.scaled) begin
      pos = PARAM_VALUE[19:0];
    end else begin
      pos = {PARAM_VALUE[15:0], 4'h0};
    end
  end

  // Effective settings, clamped to legal range
  always_comb begin
    if (sim_pulses_per_rev < `ENCSIM_PPR_MIN) begin
      ppr_lin = `ENCSIM_PPR_MIN;
    end else begin
      ppr_lin = sim_pulses_per_rev;
    end
    if (sim_pulses_per_rev > `ENCSIM_EXP_MAX) begin
      ppr_exp = 5'(`ENCSIM_EXP_MAX);
    end else begin
      ppr_exp = sim_pulses_per_rev[4:0];
    end
  end

  // Edge count target: four edges per pulse over one turn
  always_comb begin
    prod = {16'h0000, pos} * {20'h0_0000, ppr_lin};
    if (ctrl.exp_sel) begin
      span = 21'h00_0004 << ppr_exp;
      target = {1'b0, pos} >> (5'd18 - ppr_exp);
    end else begin
      span = {3'b000, ppr_lin, 2'b00};
      target = {3'b000, prod[35:18]};
    end
  end

  //--------------------------------------------------------------
  // Target register
  //--------------------------------------------------------------

  // Span and target settle here, so the wide product and the follower
  // compare never share one cycle; both move together, never out of step
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      span_q <= {3'b000, `ENCSIM_PPR_RST, 2'b00};
      target_q <= 21'h00_0000;
    end else if (CE) begin
      span_q <= span;
      target_q <= target;
    end
  end

  //--------------------------------------------------------------
  // Rate-limited quadrature follower
  //--------------------------------------------------------------

  // Shortest way round the turn decides direction
  always_comb begin
    diff = {1'b0, target_q} - {1'b0, cur};
    if (diff[21]) begin
      diff = diff + {1'b0, span_q};
    end
    fwd = diff[20:0];
    step_up = (fwd != 21'h00_0000) && (fwd <= {1'b0, span_q[20:1]}) && (gap == 6'h00);
    step_dn = (fwd != 21'h00_0000) && (fwd > {1'b0, span_q[20:1]}) && (gap == 6'h00);
  end

  // Edge counter, one quadrature edge per step
  // A shrunken span folds the count into the first pulse: A and B keep their levels
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      cur <= 21'h00_0000;
    end else if (CE) begin
      if (cur >= span_q) begin
        cur <= {19'h0_0000, cur[1:0]};
      end else if (step_up) begin
        cur <= (cur == span_q - 21'h00_0001) ? 21'h00_0000 : cur + 21'h00_0001;
      end else if (step_dn) begin
        cur <= (cur == 21'h00_0000) ? span_q - 21'h00_0001 : cur - 21'h00_0001;
      end
    end
  end

  // Minimum spacing between edges: one step per EDGE_GAP + 1 cycles,
  // four steps make one pulse period on A
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      gap <= 6'h00;
    end else if (CE) begin
      if (step_up || step_dn) begin
        gap <= EDGE_GAP;
      end else if (gap != 6'h00) begin
        gap <= gap - 6'h01;
      end
    end
  end

  // Line decode from the edge count
  always_comb begin
    next_lines.a = cur[1] ^ cur[0];
    next_lines.b = cur[1];
    next_lines.c = (cur[20:2] == 19'h0_0000);
  end

  // Both connectors driven from their own flops
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      ENC_OUT1 <= 3'b001;
      ENC_OUT2 <= 3'b001;
    end else if (CE) begin
      ENC_OUT1 <= next_lines;
      ENC_OUT2 <= next_lines;
    end
  end

endmodule : encoder_simulation_output
`default_nettype wire

// ==== verification/encsim_checker.sv ====
// Port assertions for the encoder simulation output block
`timescale 1ns/1ps
`default_nettype none
module encsim_checker
  import encsim_pkg::*;
(
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic S_AXI_AWREADY,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [1:0] S_AXI_BRESP,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire enc_lines_s ENC_OUT1,
  input wire enc_lines_s ENC_OUT2
);
  logic [1:0] prev_ab;
  logic [7:0] gap;
  // Last A/B level pair
  always_ff @(posedge CLK) begin
    prev_ab <= {ENC_OUT1.a, ENC_OUT1.b};
  end
  // Cycles since the last A/B edge, saturating
  always_ff @(posedge CLK) begin
    if (SYS_RST) gap <= 8'h3F;
    else if ({ENC_OUT1.a, ENC_OUT1.b} != prev_ab) gap <= 8'h01;
    else if (gap != 8'hFF) gap <= gap + 8'h01;
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  chk_two_conn: assert property (ENC_OUT1 == ENC_OUT2)
    else $error("connector lines differ");
  chk_edge_gap: assert property ({ENC_OUT1.a, ENC_OUT1.b} != prev_ab |-> gap >= 8'h3F)
    else $error("encoder edges too close");
  chk_quad_step: assert property (!($changed(ENC_OUT1.a) && $changed(ENC_OUT1.b)))
    else $error("A and B moved together");
  chk_b_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("write response dropped");
  chk_r_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("read data dropped");
  chk_read_lat: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
    else $error("read answer late");
  chk_aw_block: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY)
    else $error("address taken during response");
  chk_ar_block: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
    else $error("read taken during answer");
  cover property (S_AXI_BVALID && S_AXI_BREADY);
  cover property (S_AXI_RVALID && S_AXI_RREADY);
  cover property ($rose(ENC_OUT1.c));
endmodule : encsim_checker
bind encoder_simulation_output encsim_checker encsim_checker_i (.CLK, .SYS_RST, .S_AXI_AWREADY,
  .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_BRESP, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RVALID,
  .S_AXI_RREADY, .S_AXI_RDATA, .ENC_OUT1, .ENC_OUT2);
`default_nettype wire

// ==== verification/quad_counter.sv ====
// Quadrature counter standing in for the motion controller
`timescale 1ns/1ps
`default_nettype none
module quad_counter
  import encsim_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire enc_lines_s lines,
  output int pos,
  output logic [15:0] zeros
);
  enc_lines_s last;
  // Count edges by direction, count zero trace rises
  always @(posedge clk) begin
    last <= lines;
    if (rst) begin
      pos <= 0;
      zeros <= 16'h0000;
    end else begin
      if (lines.a != last.a) pos <= pos + ((lines.a != lines.b) ? 1 : -1);
      else if (lines.b != last.b) pos <= pos + ((lines.a == lines.b) ? 1 : -1);
      if (lines.c && !last.c) zeros <= zeros + 16'h0001;
    end
  end
endmodule : quad_counter
`default_nettype wire

// ==== verification/tb.sv ====
// Self-checking bench for the encoder simulation output block
`timescale 1ns/1ps
`default_nettype none
module tb
  import encsim_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic [3:0] strb = 4'h3;
  logic [1:0] exp_resp = 2'b00;
  logic awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0;
  logic [31:0] wdata = 32'h0000_0000, param = 32'h0000_0000, rdata;
  logic [19:0] shaft = 20'h0_0000;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [15:0] ptr, zeros, z0;
  enc_lines_s out1, out2;
  int pos;
  int mismatches = 0, n_compared = 0;
  encoder_simulation_output encoder_simulation_output_i (.CLK(clk), .SYS_RST(rst), .CE(ce),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(strb), .S_AXI_WVALID(wv), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .SHAFT_POS(shaft), .PARAM_VALUE(param), .SIM_SOURCE_POINTER(ptr),
    .ENC_OUT1(out1), .ENC_OUT2(out2));
  quad_counter quad_counter_i (.clk(clk), .rst(rst), .lines(out1), .pos(pos), .zeros(zeros));
  // 100 MHz clock
  always #5 clk = ~clk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    awaddr <= a;
    awv <= 1'b1;
    wdata <= d;
    wv <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (awready) awv <= 1'b0;
      if (wready) wv <= 1'b0;
    end while (!bvalid && n < 50);
    bready <= 1'b0;
    chk({29'h0, bvalid, bresp}, {29'h0, 1'b1, exp_resp});
    if (!bvalid) print_verdict(); // Timeout
  endtask : wr
  task automatic rc(input logic [3:0] a, input logic [31:0] ex);
    int n;
    n = 0;
    @(posedge clk);
    araddr <= a;
    arv <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (arready) arv <= 1'b0;
    end while (!rvalid && n < 50);
    rready <= 1'b0;
    chk(rdata, ex);
    chk({29'h0, rvalid, rresp}, {29'h0, 1'b1, exp_resp});
    if (!rvalid) print_verdict(); // Timeout
  endtask : rc
  // Move the source, let edges run out, compare the far-side count
  task automatic go(input logic [19:0] s, input logic [31:0] p, input int ex);
    @(posedge clk);
    shaft <= s;
    param <= p;
    repeat (700) @(posedge clk);
    chk(pos, ex);
  endtask : go
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : print_verdict
  // Hang guard
  initial begin
    repeat (50000) @(posedge clk);
    mismatches++;
    print_verdict();
  end
  // Main sequence
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rc(4'h0, 32'h0000_0400);
    rc(4'h4, 32'h0);
    wr(4'h8, 32'h0047);
    chk({16'h0, ptr}, 32'h0047);
    $display("test reset done");
    wr(4'h0, 32'h4);
    rc(4'h0, 32'h4);
    go(20'h5_0000, 32'h0, 5);
    go(20'h0_0000, 32'h0, 0);
    z0 = zeros;
    for (int i = 1; i <= 16; i++) go(20'(i << 16), 32'h0, i);
    chk({16'h0, zeros - z0}, 32'h1);
    $display("test linear done");
    wr(4'h0, 32'h1);
    go(20'h5_0000, 32'h0, 21);
    go(20'h0_0000, 32'h0, 16);
    wr(4'h4, 32'h1);
    go(20'h6_0000, 32'h0, 19);
    go(20'h0_0000, 32'h0, 16);
    wr(4'h0, 32'h1E);
    go(20'h0_0005, 32'h0, 21);
    go(20'h0_0000, 32'h0, 16);
    $display("test exponent done");
    wr(4'h0, 32'h4);
    wr(4'h4, 32'h8);
    go(20'h0_0000, 32'h2000, 18);
    go(20'h0_0000, 32'h0, 16);
    wr(4'h4, 32'h108);
    go(20'h0_0000, 32'h2_0000, 18);
    $display("test source done");
    ce <= 1'b0;
    go(20'h0_0000, 32'h3_0000, 18);
    ce <= 1'b1;
    go(20'h0_0000, 32'h3_0000, 19);
    rc(4'hC, 32'h3);
    exp_resp = 2'b10;
    rc(4'h2, 32'h0);
    wr(4'h6, 32'h0000_FFFF);
    exp_resp = 2'b00;
    rc(4'h8, 32'h0047);
    strb <= 4'h1;
    wr(4'h0, 32'h0000_AB40);
    strb <= 4'h3;
    rc(4'h0, 32'h0040);
    $display("test bus done");
    print_verdict();
  end
endmodule : tb
`default_nettype wire
